// file: hdl/deau_top.sv
// deau_top: register access unit for a 128-byte data eeprom
// assumes an axi4-lite master and synchronous reset-source pulses
// Function
// [RQ1] 8-bit read/write data register holds byte to write or last byte read
// [RQ2] address register bits 6..0 select one of 128 bytes, bit 7 ignored
// [RQ3] control register implements four low bits, upper four read zero
// [RQ4] software may only set read and write strobes; hardware clears them
// [RQ5] read strobe loads addressed byte into data register by next cycle
// [RQ6] data register keeps a read result until next read or software write
// [RQ7] write starts only after 55h then AAh to unlock, then write strobe
// [RQ8] unlock steps must fall within the counted cycle window, else no write
// [RQ9] write strobe ignored while write-allow bit is clear
// [RQ10] clearing write-allow does not affect a started write
// [RQ11] write-allow cleared only at power-up, never by hardware otherwise
// [RQ12] write end clears write strobe and sets done flag; software clears it
// [RQ13] abort flag set when reset, watchdog or brown-out cuts a write short
// [RQ14] aborting reset clears data and address; software reloads and retries
// [RQ15] unlock register has no storage and reads as zero
// [RQ16] no eeprom write while the power-up timer still runs
// [RQ17] data protection setting leaves cpu read and write access unchanged
// [RQ18] software should mask interrupts across the unlock sequence
// [RQ19] software should write zero to the address register top bit
// [RQ20] a byte write erases the location before programming it
// [RQ21] self-timed write period is a cycle count; write strobe held until done
`timescale 1ns/100ps
module deau_top #(
  parameter int PWRT_CYCLES = deau_pkg::PWRT_CYCLES,
  parameter int WRITE_CYCLES = deau_pkg::WRITE_CYCLES,
  parameter int UNLOCK_STEP_CYCLES = deau_pkg::UNLOCK_STEP_CYCLES
) (
  input wire logic clock_in, // 100 MHz core clock
  input wire logic srst_in, // power-on reset, sync, high
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic ext_reset_pin_in, // external reset event
  input wire logic watchdog_reset_in, // watchdog reset in normal operation
  input wire logic brownout_detect_in, // brown-out reset event
  input wire logic data_protect_cfg_in, // data protection cfg, 0 = protected
  input wire logic [deau_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [deau_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic write_done_flag_out, // write complete flag, sticky
  output logic busy_out // write cycle in progress
);

  localparam int PW = $clog2(PWRT_CYCLES + 1);
  localparam int WW = $clog2(WRITE_CYCLES + 1);
  localparam int UW = $clog2(UNLOCK_STEP_CYCLES + 1);

  // decodes a byte address to a register index
  function automatic logic [9:0] reg_index(input logic [deau_pkg::AXI_ADDR_W-1:0] a);
    return a[deau_pkg::AXI_ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [9:0] idx);
    return (idx == deau_pkg::IDX_IRQ_FLAGS) || (idx == deau_pkg::IDX_DATA) ||
           (idx == deau_pkg::IDX_ADDR) || (idx == deau_pkg::IDX_CTRL) ||
           (idx == deau_pkg::IDX_UNLOCK) || (idx == deau_pkg::IDX_STATUS);
  endfunction : is_mapped

  logic aw_hold_q;
  logic [deau_pkg::AXI_ADDR_W-1:0] aw_addr_q;
  logic w_hold_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] data_q;
  logic [7:0] addr_q;
  deau_pkg::deau_ctrl_t ctrl_q;
  logic done_q;
  deau_pkg::deau_unlock_t ul_q;
  logic [UW-1:0] ul_cnt_q;
  logic [PW-1:0] pwrt_cnt_q;
  logic pwrt_done;
  logic [WW-1:0] wcnt_q;
  logic [deau_pkg::MEM_AW-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] mem_rdata;
  deau_pkg::deau_mem_req_t mem_req;
  logic wr_fire;
  logic wr_en;
  logic [9:0] w_idx;
  logic aux_rst;
  logic wr_start;
  logic wr_finish;
  logic rd_start;
  logic ctrl_we;
  logic data_we;

  // handshakes stall while the clock enable is low so no beat is lost
  assign s_axi_awready = ce_in && !aw_hold_q && !bvalid_q;
  assign s_axi_wready = ce_in && !w_hold_q && !bvalid_q;
  assign s_axi_arready = ce_in && !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign write_done_flag_out = done_q;
  assign busy_out = ctrl_q.wr;

  // a register write happens once both address and data are held
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign w_idx = reg_index(aw_addr_q);
  assign wr_en = wr_fire && w_lane_q;
  assign ctrl_we = wr_en && (w_idx == deau_pkg::IDX_CTRL);
  assign data_we = wr_en && (w_idx == deau_pkg::IDX_DATA);
  assign aux_rst = ext_reset_pin_in || watchdog_reset_in || brownout_detect_in;
  assign pwrt_done = (pwrt_cnt_q == PW'(PWRT_CYCLES));

  // write start needs allow, the armed unlock, an idle engine and a finished timer
  assign wr_start = ctrl_we && w_byte_q[deau_pkg::CTRL_WR_BIT] && ctrl_q.allow && // RQ9
                    (ul_q == deau_pkg::UL_ARMED) && // RQ7 RQ8
                    pwrt_done && !ctrl_q.wr && !aux_rst; // RQ16
  assign wr_finish = ctrl_q.wr && (wcnt_q == WW'(WRITE_CYCLES - 1)) && !aux_rst; // RQ21
  // reads are refused while a write owns the array
  assign rd_start = ctrl_we && w_byte_q[deau_pkg::CTRL_RD_BIT] && !ctrl_q.wr && !aux_rst;

  // write address and data channels, taken in either order
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= deau_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(w_idx) ? deau_pkg::RESP_OKAY : deau_pkg::RESP_DECERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel; the answer is registered one cycle after the address
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= deau_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q <= is_mapped(reg_index(s_axi_araddr)) ? deau_pkg::RESP_OKAY
                                                        : deau_pkg::RESP_DECERR;
        rdata_q <= 32'h0000_0000;
        case (reg_index(s_axi_araddr))
          deau_pkg::IDX_IRQ_FLAGS: rdata_q[deau_pkg::IRQ_DONE_BIT] <= done_q;
          deau_pkg::IDX_DATA: rdata_q[7:0] <= data_q; // RQ1
          deau_pkg::IDX_ADDR: rdata_q[7:0] <= addr_q;
          deau_pkg::IDX_CTRL: rdata_q[3:0] <= ctrl_q; // RQ3
          deau_pkg::IDX_STATUS: begin
            rdata_q[deau_pkg::STAT_BUSY_BIT] <= ctrl_q.wr;
            rdata_q[deau_pkg::STAT_PWRT_BIT] <= !pwrt_done;
            rdata_q[deau_pkg::STAT_PROT_BIT] <= data_protect_cfg_in;
          end
          default: rdata_q <= 32'h0000_0000; // RQ15
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // power-up timer counts once after power-on reset only
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pwrt_cnt_q <= '0;
    end else if (ce_in && !pwrt_done) begin
      pwrt_cnt_q <= pwrt_cnt_q + PW'(1); // RQ16
    end
  end

  // unlock tracker: any other register write in between breaks the chain
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ul_q <= deau_pkg::UL_IDLE;
      ul_cnt_q <= '0;
    end else if (ce_in) begin
      if (aux_rst) begin
        ul_q <= deau_pkg::UL_IDLE;
      end else if (wr_en) begin
        ul_cnt_q <= '0;
        case (ul_q)
          deau_pkg::UL_IDLE, deau_pkg::UL_ARMED: begin
            ul_q <= (w_idx == deau_pkg::IDX_UNLOCK && w_byte_q == deau_pkg::UNLOCK_KEY1)
                    ? deau_pkg::UL_GOT_KEY1 : deau_pkg::UL_IDLE; // RQ7
          end
          deau_pkg::UL_GOT_KEY1: begin
            if (w_idx == deau_pkg::IDX_UNLOCK && w_byte_q == deau_pkg::UNLOCK_KEY2) begin
              ul_q <= deau_pkg::UL_ARMED; // RQ7
            end else if (w_idx == deau_pkg::IDX_UNLOCK && w_byte_q == deau_pkg::UNLOCK_KEY1) begin
              ul_q <= deau_pkg::UL_GOT_KEY1;
            end else begin
              ul_q <= deau_pkg::UL_IDLE;
            end
          end
          default: ul_q <= deau_pkg::UL_IDLE;
        endcase
      end else if (ul_q != deau_pkg::UL_IDLE) begin
        // a step that comes too late voids the sequence
        if (ul_cnt_q == UW'(UNLOCK_STEP_CYCLES)) begin
          ul_q <= deau_pkg::UL_IDLE; // RQ8
        end else begin
          ul_cnt_q <= ul_cnt_q + UW'(1); // RQ8
        end
      end
    end
  end

  // data and address registers; an aborting reset wipes both
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      data_q <= deau_pkg::DATA_RST;
      addr_q <= deau_pkg::ADDR_RST;
    end else if (ce_in) begin
      if (aux_rst) begin
        data_q <= deau_pkg::DATA_RST; // RQ14
        addr_q <= deau_pkg::ADDR_RST; // RQ14
      end else if (ctrl_q.rd) begin
        data_q <= mem_rdata; // RQ5
      end else if (data_we) begin
        data_q <= w_byte_q; // RQ6
      end else if (wr_en && w_idx == deau_pkg::IDX_ADDR) begin
        addr_q <= w_byte_q; // bit 7 is stored and read back but never addresses the array
      end
    end
  end

  // control register; strobes are set-only from software
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_q <= '0; // RQ11
    end else if (ce_in) begin
      if (aux_rst) begin
        if (ctrl_q.wr) begin
          ctrl_q.abort <= 1'b1; // RQ13
        end
        ctrl_q.wr <= 1'b0;
        ctrl_q.rd <= 1'b0;
      end else begin
        if (ctrl_we) begin
          ctrl_q.abort <= w_byte_q[deau_pkg::CTRL_ABORT_BIT];
          ctrl_q.allow <= w_byte_q[deau_pkg::CTRL_ALLOW_BIT]; // RQ10 RQ11
        end
        if (wr_start) begin
          ctrl_q.wr <= 1'b1; // RQ4
        end else if (wr_finish) begin
          ctrl_q.wr <= 1'b0; // RQ12
        end
        // read strobe lives one cycle, while the array answers
        ctrl_q.rd <= rd_start; // RQ4 RQ5
      end
    end
  end

  // self-timed write engine: erase at start, program at the end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wcnt_q <= '0;
      wr_addr_q <= '0;
      wr_data_q <= 8'h00;
    end else if (ce_in) begin
      if (wr_start) begin
        wcnt_q <= '0;
        wr_addr_q <= addr_q[deau_pkg::MEM_AW-1:0]; // RQ2
        wr_data_q <= data_q;
      end else if (ctrl_q.wr) begin
        wcnt_q <= wcnt_q + WW'(1); // RQ21
      end
    end
  end

  // done flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      done_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_finish) begin
        done_q <= 1'b1; // RQ12
      end else if (wr_en && w_idx == deau_pkg::IDX_IRQ_FLAGS) begin
        done_q <= w_byte_q[deau_pkg::IRQ_DONE_BIT];
      end
    end
  end

  // array port; protection setting does not gate cpu access
  always_comb begin
    mem_req.we = wr_start || wr_finish; // RQ17
    mem_req.re = rd_start;
    mem_req.wdata = wr_start ? deau_pkg::ERASED_BYTE : wr_data_q; // RQ20
    mem_req.addr = (wr_start || rd_start) ? addr_q[deau_pkg::MEM_AW-1:0] : wr_addr_q; // RQ2
  end

  deau_mem #(
    .DEPTH(deau_pkg::MEM_DEPTH),
    .AW(deau_pkg::MEM_AW)
  ) i_deau_mem (
    .clock_in(clock_in),
    .ce_in(ce_in),
    .req_in(mem_req),
    .rdata_out(mem_rdata)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in || !ce_in);

  sequence write_begins;
    !ctrl_q.wr ##1 ctrl_q.wr;
  endsequence

  unlock_read_zero_a: assert property ( // RQ15
    (s_axi_arvalid && s_axi_arready && reg_index(s_axi_araddr) == deau_pkg::IDX_UNLOCK)
    |=> (s_axi_rdata == 32'h0000_0000)) else $error("unlock register read not zero");
  read_loads_data_a: assert property ( // RQ5
    rd_start && !ctrl_q.rd |=> ctrl_q.rd ##1 (!ctrl_q.rd && data_q == $past(mem_rdata)))
    else $error("read strobe did not load data");
  start_needs_allow_a: assert property ( // RQ9
    write_begins |-> $past(ctrl_q.allow)) else $error("write started without allow");
  start_needs_unlock_a: assert property ( // RQ7
    write_begins |-> $past(ul_q) == deau_pkg::UL_ARMED) else $error("write without unlock");
  pwrt_blocks_write_a: assert property ( // RQ16
    !pwrt_done |-> !ctrl_q.wr) else $error("write during power-up timer");
  write_held_a: assert property ( // RQ21
    ctrl_q.wr && !wr_finish && !aux_rst |=> ctrl_q.wr) else $error("write strobe dropped early");
  done_on_finish_a: assert property ( // RQ12
    wr_finish |=> !ctrl_q.wr && done_q) else $error("write end without done flag");
  abort_clears_regs_a: assert property ( // RQ13
    aux_rst && ctrl_q.wr |=> ctrl_q.abort && data_q == 8'h00 && addr_q == 8'h00)
    else $error("aborted write not flagged");
  allow_sw_only_a: assert property ( // RQ11
    $changed(ctrl_q.allow) |-> $past(ctrl_we)) else $error("allow bit changed by hardware");
  data_kept_a: assert property ( // RQ6
    $changed(data_q) |-> $past(ctrl_q.rd || data_we || aux_rst))
    else $error("data register changed without cause");

endmodule : deau_top

// file: hdl/deau_pkg.sv
// deau_pkg: constants and types shared by the data eeprom access unit
// assumes a 100 MHz core clock and 32-bit axi4-lite register access
package deau_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_DATA = 10'h09A;
  localparam logic [9:0] IDX_ADDR = 10'h09B;
  localparam logic [9:0] IDX_CTRL = 10'h09C;
  localparam logic [9:0] IDX_UNLOCK = 10'h09D;
  localparam logic [9:0] IDX_STATUS = 10'h0A0;
  localparam int AXI_ADDR_W = 12;

  // field positions
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_ALLOW_BIT = 2;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int IRQ_DONE_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PWRT_BIT = 1;
  localparam int STAT_PROT_BIT = 2;

  // reset values and fixed codes
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // memory geometry
  localparam int MEM_DEPTH = 128;
  localparam int MEM_AW = 7;

  // timing: figures in their own units, cycle counts derived from the clock
  localparam int CLK_MHZ = 100;
  localparam int PWRT_MS = 72;
  localparam int PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
  localparam int WRITE_US = 5;
  localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
  localparam int UNLOCK_STEP_CYCLES = 64;

  // control register image
  typedef struct packed {
    logic abort;
    logic allow;
    logic wr;
    logic rd;
  } deau_ctrl_t;

  // memory port bundle
  typedef struct packed {
    logic we;
    logic re;
    logic [MEM_AW-1:0] addr;
    logic [7:0] wdata;
  } deau_mem_req_t;

  // unlock tracker states
  typedef enum logic [1:0] {
    UL_IDLE,
    UL_GOT_KEY1,
    UL_ARMED
  } deau_unlock_t;

endpackage : deau_pkg

// file: hdl/deau_mem.sv
// deau_mem: byte array standing in for the eeprom cells
// assumes one request per cycle; read data are registered
`timescale 1ns/100ps
module deau_mem #(
  parameter int DEPTH = deau_pkg::MEM_DEPTH,
  parameter int AW = deau_pkg::MEM_AW
) (
  input wire logic clock_in, // core clock
  input wire logic ce_in, // clock enable, freezes the array
  input wire deau_pkg::deau_mem_req_t req_in, // read/write request
  output logic [7:0] rdata_out // registered read data
);

  logic [7:0] cells_q [DEPTH];

  // write port; cells are not reset, like a real nonvolatile array
  always_ff @(posedge clock_in) begin
    if (ce_in && req_in.we) begin
      cells_q[req_in.addr] <= req_in.wdata;
    end
  end

  // registered read port
  always_ff @(posedge clock_in) begin
    if (ce_in && req_in.re) begin
      rdata_out <= cells_q[req_in.addr];
    end
  end

endmodule : deau_mem

// file: testbench/deau_top_test.sv
// deau_top_test: self-checking bench for the data eeprom access unit
// assumes deau_top with axi4-lite registers; the bench is the only bus master
`timescale 1ns/100ps
module deau_top_test;
  localparam int PWRT = 200; // long enough to try a write before it expires
  localparam int WCYC = 8;
  localparam logic [11:0] A_IRQ = {deau_pkg::IDX_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] A_DATA = {deau_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_ADDR = {deau_pkg::IDX_ADDR, 2'h0};
  localparam logic [11:0] A_CTRL = {deau_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_UNL = {deau_pkg::IDX_UNLOCK, 2'h0};
  localparam logic [11:0] A_STAT = {deau_pkg::IDX_STATUS, 2'h0};
  logic clock_in = 1'h0;
  logic srst_in, ce_in, ext_in, wdog_in, bod_in, prot_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, done_flag, busy;
  logic [1:0] bresp, rresp, resp;
  int errors = 0;
  int cmp_count = 0;
  int n;

  deau_top #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WCYC), .UNLOCK_STEP_CYCLES(64)) i_deau_top (
    .clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in), .ext_reset_pin_in(ext_in),
    .watchdog_reset_in(wdog_in), .brownout_detect_in(bod_in), .data_protect_cfg_in(prot_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_done_flag_out(done_flag), .busy_out(busy)
  );

  // 100 MHz clock
  always #5 clock_in = ~clock_in;

  // one comparison, counted; a mismatch is reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  // write cycle: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock_in);
      k++;
      if (awvalid && awready) begin
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
      end
    end while (!(bvalid && bready) && k < 100);
    chk1(bvalid, 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge clock_in); // an edge between transfers keeps drivers single-valued
  endtask : axi_wr

  // read cycle: rready held until the answer is sampled
  task automatic axi_rd(input logic [11:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock_in);
      k++;
      if (arvalid && arready) begin
        arvalid <= 1'h0;
      end
    end while (!(rvalid && rready) && k < 100);
    chk1(rvalid, 1'h1);
    rv = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge clock_in);
  endtask : axi_rd

  // full byte write: address, data, allow, two keys, then the strobe
  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    axi_wr(A_ADDR, a);
    axi_wr(A_DATA, d);
    axi_wr(A_CTRL, 8'h04);
    // nothing else may reach the bus between these three steps
    axi_wr(A_UNL, deau_pkg::UNLOCK_KEY1);
    axi_wr(A_UNL, deau_pkg::UNLOCK_KEY2);
    axi_wr(A_CTRL, 8'h06);
  endtask : prog

  task automatic rd_mem(input logic [7:0] a);
    axi_wr(A_ADDR, a);
    axi_wr(A_CTRL, 8'h05);
    axi_rd(A_DATA);
  endtask : rd_mem

  // bounded wait for the self-timed cycle; n holds the cycles seen busy
  task automatic wait_idle();
    n = 0;
    while (busy && n < 100) begin
      @(posedge clock_in);
      n++;
    end
  endtask : wait_idle

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    srst_in = 1'h1;
    ce_in = 1'h1;
    ext_in = 1'h0;
    wdog_in = 1'h0;
    bod_in = 1'h0;
    prot_in = 1'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'h0;
    @(posedge clock_in);
    // reset values
    axi_rd(A_DATA);
    check(rv, 32'h0);
    axi_rd(A_ADDR);
    check(rv, 32'h0);
    axi_rd(A_CTRL);
    check(rv, 32'h0);
    axi_rd(A_IRQ);
    check(rv, 32'h0);
    axi_rd(A_STAT);
    chk1(rv[1], 1'h1);
    chk1(rv[2], 1'h0);
    // a correct sequence while the power-up timer runs must not start
    prog(8'h05, 8'h3C);
    chk1(busy, 1'h0);
    axi_rd(A_CTRL);
    check(rv, 32'h04);
    for (int i = 0; i < 100; i++) begin
      axi_rd(A_STAT);
      if (!rv[1]) begin
        break;
      end
    end
    chk1(rv[1], 1'h0);
    // unmapped place answers with a decode error
    axi_rd(12'h004);
    check({30'h0, resp}, {30'h0, deau_pkg::RESP_DECERR});
    check(rv, 32'h0);
    axi_wr(12'h004, 8'h11);
    check({30'h0, resp}, {30'h0, deau_pkg::RESP_DECERR});
    // top address bit is ignored; software cannot clear the strobe or stop the write
    prog(8'h85, 8'h3C);
    chk1(busy, 1'h1);
    axi_wr(A_CTRL, 8'h00);
    axi_rd(A_CTRL);
    check(rv, 32'h02);
    // the readback still saw the strobe, so an idle engine here bounds the duration
    wait_idle();
    check(n, 32'h0);
    chk1(done_flag, 1'h1);
    axi_rd(A_IRQ);
    check(rv, 32'h80);
    axi_rd(A_CTRL);
    check(rv, 32'h00);
    axi_wr(A_IRQ, 8'h00);
    chk1(done_flag, 1'h0);
    rd_mem(8'h05);
    check(rv, 32'h3C);
    axi_rd(A_CTRL);
    check(rv, 32'h04);
    axi_wr(A_ADDR, 8'h06);
    axi_rd(A_DATA);
    check(rv, 32'h3C);
    // a write with byte lane 0 off is answered but changes nothing
    wstrb <= 4'hE;
    axi_wr(A_DATA, 8'h5A);
    check({30'h0, resp}, {30'h0, deau_pkg::RESP_OKAY});
    wstrb <= 4'hF;
    axi_rd(A_DATA);
    check(rv, 32'h3C);
    // allow stays set after a completed write
    prog(8'h06, 8'hA5);
    wait_idle();
    chk1(n >= WCYC - 4 && n <= WCYC, 1'h1);
    axi_rd(A_CTRL);
    check(rv, 32'h04);
    rd_mem(8'h06);
    check(rv, 32'hA5);
    axi_wr(A_IRQ, 8'h00);
    axi_wr(A_UNL, 8'h55);
    axi_rd(A_UNL);
    check(rv, 32'h0);
    // broken order, an intruding write, a slow step, allow clear: none may start
    axi_wr(A_ADDR, 8'h05);
    for (int i = 0; i < 4; i++) begin
      axi_wr(A_CTRL, (i == 3) ? 8'h00 : 8'h04);
      axi_wr(A_UNL, (i == 0) ? 8'hAA : 8'h55);
      if (i == 1) begin
        axi_wr(A_DATA, 8'h99);
      end
      if (i == 2) begin
        repeat (70) @(posedge clock_in);
      end
      axi_wr(A_UNL, (i == 0) ? 8'h55 : 8'hAA);
      axi_wr(A_CTRL, (i == 3) ? 8'h02 : 8'h06);
      chk1(busy, 1'h0);
      axi_rd(A_CTRL);
      check(rv, (i == 3) ? 32'h00 : 32'h04);
    end
    rd_mem(8'h05);
    check(rv, 32'h3C);
    // protection setting is visible yet changes nothing for the cpu
    prot_in <= 1'h1;
    axi_rd(A_STAT);
    chk1(rv[2], 1'h1);
    // each reset source cuts a running write short
    for (int i = 0; i < 3; i++) begin
      prog(8'h10, 8'h77);
      chk1(busy, 1'h1);
      case (i)
        0: ext_in <= 1'h1;
        1: wdog_in <= 1'h1;
        default: bod_in <= 1'h1;
      endcase
      @(posedge clock_in);
      ext_in <= 1'h0;
      wdog_in <= 1'h0;
      bod_in <= 1'h0;
      @(posedge clock_in);
      chk1(busy, 1'h0);
      axi_rd(A_CTRL);
      check(rv, 32'h0C);
      axi_rd(A_DATA);
      check(rv, 32'h0);
      axi_rd(A_ADDR);
      check(rv, 32'h0);
      axi_wr(A_CTRL, 8'h04);
      axi_rd(A_CTRL);
      check(rv, 32'h04);
      rd_mem(8'h10);
      check(rv, {24'h0, deau_pkg::ERASED_BYTE});
    end
    // retry after the abort succeeds; a low clock enable freezes the running write
    prog(8'h10, 8'h77);
    ce_in <= 1'h0;
    repeat (20) @(posedge clock_in);
    chk1(busy, 1'h1);
    ce_in <= 1'h1;
    wait_idle();
    rd_mem(8'h10);
    check(rv, 32'h77);
    print_verdict();
  end

  // watchdog: the sequence needs well under a thousand cycles, this allows far more
  initial begin
    #300000;
    errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    print_verdict();
  end
endmodule : deau_top_test
